// >>> core/acs_pkg.sv
// Shared constants for the audio control slave
package acs_pkg;
  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int PD_DELAY_MS = 30;
  localparam int PD_CYCLES_DEF = (PD_DELAY_MS * (CLK_HZ / 1000));
  localparam int PD_CNT_W = 21;

  // ------------------------------------------------------------------
  // Two-wire addressing
  // ------------------------------------------------------------------
  localparam logic [6:0] SLV_ADDR_LO = 7'h18;
  localparam logic [6:0] SLV_ADDR_HI = 7'h19;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic RW_READ = 1'b1;

  // ------------------------------------------------------------------
  // Configuration space
  // ------------------------------------------------------------------
  localparam int REG_COUNT = 32;
  localparam logic [7:0] REG_LAST = 8'h1F;
  localparam logic [7:0] CFG_IN_FMT = 8'h01;
  localparam logic [7:0] CFG_OUT_FMT = 8'h04;
  localparam logic [7:0] MVOL_ADDR = 8'h07;
  localparam logic [7:0] CVOL_FIRST = 8'h09;
  localparam int NUM_CHAN = 8;
  localparam int FMT_LSB = 2;
  localparam int FMT_MSB = 5;
  localparam logic [3:0] FMT_COUNT = 4'h6;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] MVOL_RST = 8'hFF;
  localparam logic [7:0] CVOL_RST = 8'h00;
  localparam logic [7:0] VOL_FULL = 8'h00;

  typedef enum logic [3:0] {
    ACS_IDLE = 4'h0,
    ACS_ADDR = 4'h1,
    ACS_ADDR_ACK = 4'h2,
    ACS_REG = 4'h3,
    ACS_REG_ACK = 4'h4,
    ACS_WDATA = 4'h5,
    ACS_WDATA_ACK = 4'h6,
    ACS_RDATA = 4'h7,
    ACS_RDATA_ACK = 4'h8
  } acs_state_e;
endpackage : acs_pkg

// >>> core/acs_regs.sv
// Configuration register array with volume override
`timescale 1ns/1ps
module acs_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic volume_override_pin,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [7:0] master_volume,
  output logic [63:0] chan_volume,
  output logic [3:0] in_fmt,
  output logic [3:0] out_fmt
);
  logic [7:0] mem [acs_pkg::REG_COUNT];
  logic [3:0] raw_in;
  logic [3:0] raw_out;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  generate
    for (genvar i = 0; i < acs_pkg::REG_COUNT; i++) begin : g_reg
      localparam logic [7:0] IDX = 8'(i);
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          if (IDX == acs_pkg::MVOL_ADDR) begin
            mem[i] <= acs_pkg::MVOL_RST;
          end else if (IDX >= acs_pkg::CVOL_FIRST &&
                       IDX < acs_pkg::CVOL_FIRST + 8'(acs_pkg::NUM_CHAN)) begin
            mem[i] <= acs_pkg::CVOL_RST;
          end else begin
            mem[i] <= acs_pkg::REG_RST;
          end
        end else if (IDX == acs_pkg::MVOL_ADDR && volume_override_pin) begin
          mem[i] <= acs_pkg::VOL_FULL;
        end else if (wr_en && wr_addr == IDX) begin
          mem[i] <= wr_data;
        end
      end
    end
    for (genvar c = 0; c < acs_pkg::NUM_CHAN; c++) begin : g_chan
      assign chan_volume[8*c +: 8] = mem[int'(acs_pkg::CVOL_FIRST) + c];
    end
  endgenerate

  always_comb begin
    if (rd_addr <= acs_pkg::REG_LAST) begin
      rd_data = mem[rd_addr[4:0]];
    end else begin
      rd_data = 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Decoded settings
  // ------------------------------------------------------------------
  assign master_volume = mem[acs_pkg::MVOL_ADDR[4:0]];
  assign raw_in = mem[acs_pkg::CFG_IN_FMT[4:0]][acs_pkg::FMT_MSB:acs_pkg::FMT_LSB];
  assign raw_out = mem[acs_pkg::CFG_OUT_FMT[4:0]][acs_pkg::FMT_MSB:acs_pkg::FMT_LSB];
  // Only six formats exist; others fall back to the first
  assign in_fmt = (raw_in < acs_pkg::FMT_COUNT) ? raw_in : 4'h0;
  assign out_fmt = (raw_out < acs_pkg::FMT_COUNT) ? raw_out : 4'h0;

  a_override_zero: assert property (@(posedge clock) disable iff (!resetn)
    volume_override_pin |=> master_volume == acs_pkg::VOL_FULL)
    else $error("master volume not forced to full scale");
  a_fmt_legal: assert property (@(posedge clock) disable iff (!resetn)
    in_fmt < acs_pkg::FMT_COUNT && out_fmt < acs_pkg::FMT_COUNT)
    else $error("audio format code out of range");
endmodule : acs_regs

// >>> core/acs_pd_timer.sv
// Amplifier power-down output goes high as soon as the pin is high; it falls PD_CYCLES cycles after the pin goes low
`timescale 1ns/1ps
module acs_pd_timer #(
  parameter int PD_CYCLES = acs_pkg::PD_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic powerdown_pin,
  output logic amp_powerdown_out
);
  localparam logic [acs_pkg::PD_CNT_W-1:0] LAST = acs_pkg::PD_CNT_W'(PD_CYCLES - 1);
  logic [acs_pkg::PD_CNT_W-1:0] cnt;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else if (powerdown_pin) begin
      cnt <= '0;
    end else if (cnt != LAST) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      amp_powerdown_out <= 1'b0;
    end else if (powerdown_pin) begin
      amp_powerdown_out <= 1'b1;
    end else if (cnt == LAST) begin
      amp_powerdown_out <= 1'b0;
    end
  end

  a_pd_hold: assert property (@(posedge clock) disable iff (!resetn)
    (amp_powerdown_out && !powerdown_pin && cnt != LAST) |=> amp_powerdown_out)
    else $error("amplifier powered down too early");
  a_pd_drop: assert property (@(posedge clock) disable iff (!resetn)
    (!powerdown_pin && cnt == LAST) |=> !amp_powerdown_out)
    else $error("amplifier power-down late");
endmodule : acs_pd_timer

// >>> core/acs_top.sv
// Two-wire control slave with pin-level audio controls
`timescale 1ns/1ps
module acs_top #(
  parameter int PD_CYCLES = acs_pkg::PD_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  input wire logic volume_override_pin,
  input wire logic powerdown_pin,
  output logic amp_powerdown_out,
  output logic outputs_enable,
  output logic [7:0] master_volume,
  output logic [63:0] chan_volume,
  output logic [3:0] in_fmt,
  output logic [3:0] out_fmt
);
  acs_pkg::acs_state_e state;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic rw;
  logic [6:0] own_addr;
  logic byte_done;
  logic wr_en;
  logic [7:0] rd_data;

  // ------------------------------------------------------------------
  // Bus condition detection
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_cond = scl && scl_q && sda_q && !sda_in;
  assign stop_cond = scl && scl_q && !sda_q && sda_in;
  assign byte_done = scl_fall && bit_cnt == acs_pkg::BITS_PER_BYTE;
  assign own_addr = address_select_pin ? acs_pkg::SLV_ADDR_HI : acs_pkg::SLV_ADDR_LO;
  assign wr_en = state == acs_pkg::ACS_WDATA && byte_done && !start_cond && !stop_cond;

  // ------------------------------------------------------------------
  // Transfer sequencing (slave only, master clocks)
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= acs_pkg::ACS_IDLE;
    end else if (stop_cond) begin
      state <= acs_pkg::ACS_IDLE;
    end else if (start_cond) begin
      state <= acs_pkg::ACS_ADDR;
    end else if (scl_fall) begin
      case (state)
        acs_pkg::ACS_ADDR: begin
          if (bit_cnt == acs_pkg::BITS_PER_BYTE) begin
            if (shreg[7:1] == own_addr) begin
              state <= acs_pkg::ACS_ADDR_ACK;
            end else begin
              state <= acs_pkg::ACS_IDLE;
            end
          end
        end
        acs_pkg::ACS_ADDR_ACK: begin
          state <= (rw == acs_pkg::RW_READ) ? acs_pkg::ACS_RDATA : acs_pkg::ACS_REG;
        end
        acs_pkg::ACS_REG: begin
          if (bit_cnt == acs_pkg::BITS_PER_BYTE) begin
            state <= acs_pkg::ACS_REG_ACK;
          end
        end
        acs_pkg::ACS_REG_ACK: begin
          state <= acs_pkg::ACS_WDATA;
        end
        acs_pkg::ACS_WDATA: begin
          if (bit_cnt == acs_pkg::BITS_PER_BYTE) begin
            state <= acs_pkg::ACS_WDATA_ACK;
          end
        end
        acs_pkg::ACS_WDATA_ACK: begin
          state <= acs_pkg::ACS_WDATA;
        end
        acs_pkg::ACS_RDATA: begin
          if (bit_cnt == acs_pkg::BITS_PER_BYTE) begin
            state <= acs_pkg::ACS_RDATA_ACK;
          end
        end
        acs_pkg::ACS_RDATA_ACK: begin
          // Master acknowledge asks for the next byte
          state <= shreg[0] ? acs_pkg::ACS_IDLE : acs_pkg::ACS_RDATA;
        end
        default: begin
          state <= acs_pkg::ACS_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Bit counting and sampling
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 4'h0;
    end else if (start_cond || stop_cond) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && state != acs_pkg::ACS_IDLE) begin
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_fall && (bit_cnt == 4'h9 || state == acs_pkg::ACS_IDLE)) begin
      // Cleared after the acknowledge slot, so every byte counts from zero
      bit_cnt <= 4'h0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shreg <= 8'h00;
    end else if (scl_rise) begin
      shreg <= {shreg[6:0], sda_in};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rw <= 1'b0;
    end else if (state == acs_pkg::ACS_ADDR && byte_done) begin
      rw <= shreg[0];
    end
  end

  // ------------------------------------------------------------------
  // Register pointer, auto-incremented per data byte
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ptr <= 8'h00;
    end else if (state == acs_pkg::ACS_REG && byte_done && !start_cond && !stop_cond) begin
      ptr <= shreg;
    end else if (wr_en) begin
      ptr <= ptr + 8'h01;
    end else if (state == acs_pkg::ACS_RDATA && byte_done) begin
      ptr <= ptr + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // Read shifter and SDA drive
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txreg <= 8'hFF;
    end else if (scl_fall && (state == acs_pkg::ACS_ADDR_ACK ||
                              state == acs_pkg::ACS_RDATA_ACK)) begin
      txreg <= rd_data;
    end else if (scl_fall && state == acs_pkg::ACS_RDATA) begin
      txreg <= {txreg[6:0], 1'b1};
    end
  end

  assign sda_out = 1'b0;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sda_oe <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state)
        acs_pkg::ACS_ADDR: begin
          sda_oe <= bit_cnt == acs_pkg::BITS_PER_BYTE && shreg[7:1] == own_addr;
        end
        acs_pkg::ACS_REG, acs_pkg::ACS_WDATA: begin
          sda_oe <= bit_cnt == acs_pkg::BITS_PER_BYTE;
        end
        acs_pkg::ACS_ADDR_ACK: begin
          sda_oe <= rw == acs_pkg::RW_READ && !rd_data[7];
        end
        acs_pkg::ACS_RDATA: begin
          sda_oe <= bit_cnt != acs_pkg::BITS_PER_BYTE && !txreg[6];
        end
        acs_pkg::ACS_RDATA_ACK: begin
          sda_oe <= !shreg[0] && !rd_data[7];
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Output enable held off through reset
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outputs_enable <= 1'b0;
    end else begin
      outputs_enable <= 1'b1;
    end
  end

  acs_regs u_regs (
    .clock(clock),
    .resetn(resetn),
    .volume_override_pin(volume_override_pin),
    .wr_en(wr_en),
    .wr_addr(ptr),
    .wr_data(shreg),
    .rd_addr(ptr),
    .rd_data(rd_data),
    .master_volume(master_volume),
    .chan_volume(chan_volume),
    .in_fmt(in_fmt),
    .out_fmt(out_fmt)
  );

  acs_pd_timer #(
    .PD_CYCLES(PD_CYCLES)
  ) u_pd (
    .clock(clock),
    .resetn(resetn),
    .powerdown_pin(powerdown_pin),
    .amp_powerdown_out(amp_powerdown_out)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_select_done;
    state == acs_pkg::ACS_ADDR && byte_done && !start_cond && !stop_cond;
  endsequence

  sequence s_regaddr_done;
    state == acs_pkg::ACS_REG && byte_done && !start_cond && !stop_cond;
  endsequence

  a_start_enters_addr: assert property (@(posedge clock) disable iff (!resetn)
    (start_cond && !stop_cond) |=> state == acs_pkg::ACS_ADDR && bit_cnt == 4'h0)
    else $error("start not detected");
  a_stop_ends_xfer: assert property (@(posedge clock) disable iff (!resetn)
    stop_cond |=> state == acs_pkg::ACS_IDLE && !sda_oe)
    else $error("stop did not end transfer");
  a_match_acks: assert property (@(posedge clock) disable iff (!resetn)
    (s_select_done and (shreg[7:1] == own_addr)) |=> sda_oe && !sda_out &&
      state == acs_pkg::ACS_ADDR_ACK)
    else $error("matched address not acknowledged");
  a_nomatch_release: assert property (@(posedge clock) disable iff (!resetn)
    (s_select_done and (shreg[7:1] != own_addr)) |=> !sda_oe &&
      state == acs_pkg::ACS_IDLE)
    else $error("mismatched address acknowledged");
  a_sample_rise: assert property (@(posedge clock) disable iff (!resetn)
    scl_rise |=> shreg[0] == $past(sda_in) && shreg[7:1] == $past(shreg[6:0]))
    else $error("SDA not sampled on SCL rise");
  a_regaddr_ack: assert property (@(posedge clock) disable iff (!resetn)
    s_regaddr_done |=> ptr == $past(shreg) && sda_oe)
    else $error("register address not taken or acknowledged");
  a_rw_direction: assert property (@(posedge clock) disable iff (!resetn)
    (state == acs_pkg::ACS_ADDR_ACK && scl_fall && !start_cond && !stop_cond) |=>
      state == (rw ? acs_pkg::ACS_RDATA : acs_pkg::ACS_REG))
    else $error("direction bit misread");
  a_write_advance: assert property (@(posedge clock) disable iff (!resetn)
    wr_en |=> ptr == $past(ptr) + 8'h01 && state == acs_pkg::ACS_WDATA_ACK && sda_oe)
    else $error("data byte not acknowledged or pointer stuck");
endmodule : acs_top

// >>> verif/acs_master.sv
// Two-wire bus master model facing the control slave
`timescale 1ns/1ps
module acs_master (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // Half period of the bus clock in system cycles, set by the bench
  int half = 3;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge clock);
  endtask : tk

  // Also serves as repeated start
  task automatic start();
    sda_drv = 1'b1;
    tk(half);
    scl = 1'b1;
    tk(half);
    sda_drv = 1'b0;
    tk(half);
    scl = 1'b0;
    tk(1);
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    tk(half);
    scl = 1'b1;
    tk(half);
    sda_drv = 1'b1;
    tk(half);
  endtask : stop

  // Data set while the clock is low, held across the rising edge
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tk(half);
    scl = 1'b1;
    tk(half);
    r = sda;
    scl = 1'b0;
    tk(1);
  endtask : bit_io

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : write_byte

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask : read_byte
endmodule : acs_master

// >>> verif/acs_top_bench.sv
// Self-checking bench for the audio control slave
`timescale 1ns/1ps
module acs_top_bench;
  logic clock;
  logic resetn;
  logic scl;
  logic sda;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  logic address_select_pin;
  logic ovr;
  logic powerdown_pin;
  logic amp_powerdown_out;
  logic outputs_enable;
  logic [7:0] master_volume;
  logic [63:0] chan_volume;
  logic [3:0] in_fmt;
  logic [3:0] out_fmt;
  logic [7:0] mdl [32];
  int ptr;
  int bad_count = 0;
  int cmp_count = 0;

  // Open-drain wire with pull-up
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  acs_top #(.PD_CYCLES(20)) dut (
    .clock(clock), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pin(address_select_pin), .volume_override_pin(ovr),
    .powerdown_pin(powerdown_pin), .amp_powerdown_out(amp_powerdown_out),
    .outputs_enable(outputs_enable), .master_volume(master_volume),
    .chan_volume(chan_volume), .in_fmt(in_fmt), .out_fmt(out_fmt)
  );

  acs_master m (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string s);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, s, g, e);
    end
  endtask : chk

  task automatic check_all();
    logic [63:0] cv;
    logic [3:0] f;
    for (int c = 0; c < 8; c++) cv[8*c +: 8] = mdl[9+c];
    chk(master_volume, mdl[7], "master volume");
    chk(chan_volume, cv, "channel volume");
    f = mdl[1][5:2];
    chk(in_fmt, (f < 6) ? f : 4'h0, "input format");
    f = mdl[4][5:2];
    chk(out_fmt, (f < 6) ? f : 4'h0, "output format");
  endtask : check_all

  function automatic logic [6:0] own();
    return address_select_pin ? 7'b0011001 : 7'b0011000;
  endfunction : own

  task automatic do_reset();
    resetn = 1'b0;
    repeat (10) @(negedge clock);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[7] = 8'hFF;
    ptr = 0;
    chk(outputs_enable, 1'b0, "outputs in reset");
    chk(amp_powerdown_out, 1'b0, "amp in reset");
    check_all();
    resetn = 1'b1;
    repeat (2) @(negedge clock);
    chk(outputs_enable, 1'b1, "outputs after reset");
  endtask : do_reset

  // Code below zero leaves data random
  task automatic wr(input logic [6:0] a, input int r, input int n, input int code);
    logic k;
    logic [7:0] d;
    logic hit;
    int p;
    hit = (a == own());
    m.start();
    m.write_byte({a, 1'b0}, k);
    chk(k, hit, "select ack");
    m.write_byte(8'(r), k);
    chk(k, hit, "register ack");
    p = r;
    repeat (n) begin
      d = 8'($urandom);
      if (code >= 0) d[5:2] = 4'(code);
      m.write_byte(d, k);
      chk(k, hit, "data ack");
      if (hit && p < 32 && !(p == 7 && ovr)) mdl[p] = d;
      p++;
    end
    if (hit) ptr = p;
    m.stop();
  endtask : wr

  task automatic rd(input logic [6:0] a, input int n);
    logic k;
    logic [7:0] d;
    logic hit;
    hit = (a == own());
    m.start();
    m.write_byte({a, 1'b1}, k);
    chk(k, hit, "read select ack");
    if (hit) begin
      for (int i = 0; i < n; i++) begin
        m.read_byte(i == n - 1, d);
        chk(d, (ptr < 32) ? mdl[ptr] : 8'h00, "read data");
        ptr++;
      end
    end
    m.stop();
  endtask : rd

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [6:0] a;
    logic r;
    int rg;
    resetn = 1'b0;
    address_select_pin = 1'b0;
    ovr = 1'b0;
    powerdown_pin = 1'b1;
    void'($urandom(10));
    do_reset();
    for (int it = 0; it < 8; it++) begin
      address_select_pin = 1'($urandom);
      m.half = 3 + $urandom % 4;
      a = ($urandom % 3 == 0) ? 7'($urandom) : own();
      wr(a, 7, 10, -1);
      check_all();
      rg = $urandom % 40;
      wr(a, rg, 2, -1);
      wr(a, rg, 0, -1);
      rd(a, 4);
    end
    for (int c = 0; c < 8; c++) begin
      wr(own(), 1, 4, c);
      check_all();
    end
    ovr = 1'b1;
    repeat (2) @(negedge clock);
    mdl[7] = 8'h00;
    check_all();
    wr(own(), 7, 1, -1);
    check_all();
    ovr = 1'b0;
    @(negedge clock);
    check_all();
    // Byte cut short by stop is dropped
    m.start();
    m.write_byte({own(), 1'b0}, r);
    m.write_byte(8'h09, r);
    repeat (4) m.bit_io(~mdl[9][7], r);
    m.stop();
    check_all();
    powerdown_pin = 1'b0;
    repeat (18) @(negedge clock);
    chk(amp_powerdown_out, 1'b1, "amp before delay");
    repeat (4) @(negedge clock);
    chk(amp_powerdown_out, 1'b0, "amp after delay");
    powerdown_pin = 1'b1;
    repeat (2) @(negedge clock);
    chk(amp_powerdown_out, 1'b1, "amp restored");
    do_reset();
    end_sim();
  end

  initial begin
    repeat (80000) @(posedge clock);
    bad_count++;
    $display("MISMATCH %0t run did not finish", $time);
    end_sim();
  end
endmodule : acs_top_bench
